// ---- hdl/ppc_protect_regs.sv ----
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_protect_regs (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Register port from the serial interface.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Write-enable bits from the write-enable register.
    input wire logic charge_cfg_write_enable,
    input wire logic feature_cfg_write_enable,
    // Discharge settings from the discharge register.
    input wire logic [1:0] discharge_timeout_code,
    // Analog comparator levels.
    input wire logic charge_oc_detect,
    input wire logic discharge_oc_detect,
    input wire logic short_circuit_detect,
    input wire logic ext_overtemp_detect,
    input wire logic int_overtemp_detect,
    input wire logic wake_pin,
    // Charge FET control bit, written by the host.
    input wire logic charge_fet_set,
    input wire logic charge_fet_clear,
    // Outputs to the analog side.
    output logic [1:0] charge_oc_threshold,
    output logic charge_fet_on,
    output logic power_fet_off_req,
    output logic discharge_oc_expired,
    output logic short_circuit_expired,
    output logic charge_oc_flag,
    output logic ext_overtemp_flag,
    output logic int_overtemp_flag,
    output logic temp_sensor_supply_out,
    output logic regulator_disable,
    output logic wake_event,
    output logic soft_por
);
    // Register contents and flags.
    ppc_pkg::ppc_byte_type charge_cfg;
    ppc_pkg::ppc_byte_type feature_cfg;
    ppc_pkg::ppc_byte_type next_charge_cfg;
    ppc_pkg::ppc_byte_type next_feature_cfg;
    ppc_pkg::ppc_byte_type next_rdata;
    logic next_charge_fet_on;
    logic next_coc;
    logic next_xot;
    logic next_iot;
    logic next_soft_por;
    logic wake_prev;
    logic next_wake_event;
    logic chg_expired;
    logic scan_on;
    logic [31:0] chg_limit;
    logic [31:0] dis_limit;
    logic [31:0] sc_limit;

    // Delay in cycles for a two-bit time-out code, base doubled per code step, or divided base.
    function automatic logic [31:0] delay_cycles(input logic [1:0] code, input logic div, input logic [31:0] base);
        delay_cycles = div ? (32'(`PPC_US_CYCLES(`PPC_DIV_BASE_US)) << code) : (base << code);
    endfunction : delay_cycles

    // Delay limits from the settings.
    always_comb begin
        chg_limit = delay_cycles(charge_cfg[1:0], charge_cfg[`PPC_BIT_CDIV],
                                 32'(`PPC_US_CYCLES(`PPC_CHG_BASE_US)));
        dis_limit = delay_cycles(discharge_timeout_code, charge_cfg[`PPC_BIT_DDIV],
                                 32'(`PPC_US_CYCLES(`PPC_DIS_BASE_US)));
        sc_limit = charge_cfg[`PPC_BIT_SC_LONG] ? 32'(`PPC_US_CYCLES(`PPC_SC_LONG_US))
                                                : 32'(`PPC_US_CYCLES(`PPC_SC_SHORT_US));
    end

    // Persistence timers for charge, discharge and short circuit.
    ppc_delay_timer u_chg_timer (
        .clk(clk), .rst_b(rst_b), .soft_clear(soft_por),
        .cond(charge_oc_detect), .limit(chg_limit), .expired(chg_expired)
    );
    ppc_delay_timer u_dis_timer (
        .clk(clk), .rst_b(rst_b), .soft_clear(soft_por),
        .cond(discharge_oc_detect), .limit(dis_limit), .expired(discharge_oc_expired)
    );
    ppc_delay_timer u_sc_timer (
        .clk(clk), .rst_b(rst_b), .soft_clear(soft_por),
        .cond(short_circuit_detect), .limit(sc_limit), .expired(short_circuit_expired)
    );

    // Periodic temperature scan.
    ppc_temp_scan u_scan (
        .clk(clk), .rst_b(rst_b), .soft_clear(soft_por),
        .scan_disable(feature_cfg[`PPC_BIT_SCAN_DIS]), .scan_on(scan_on)
    );

    // Register writes, flags, FET bit and wake detection.
    always_comb begin
        next_charge_cfg = charge_cfg;
        next_feature_cfg = feature_cfg;
        next_charge_fet_on = charge_fet_on;
        next_soft_por = 1'b0;
        if (reg_wr && reg_addr == `PPC_ADDR_CHARGE && charge_cfg_write_enable) begin
            next_charge_cfg = reg_wdata;
        end
        if (reg_wr && reg_addr == `PPC_ADDR_FEATURE && feature_cfg_write_enable) begin
            next_feature_cfg = reg_wdata;
            next_soft_por = reg_wdata[`PPC_BIT_FORCE_POR];
        end
        if (charge_fet_set) begin
            next_charge_fet_on = 1'b1;
        end
        if (charge_fet_clear) begin
            next_charge_fet_on = 1'b0;
        end
        // Automatic shutoff wins over a host set in the same cycle.
        if (chg_expired && !charge_cfg[`PPC_BIT_AUTOOFF_DIS]) begin
            next_charge_fet_on = 1'b0;
        end
        if ((ext_overtemp_detect && !feature_cfg[`PPC_BIT_XTSD_DIS])
            || (int_overtemp_detect && !feature_cfg[`PPC_BIT_ITSD_DIS])) begin
            next_charge_fet_on = 1'b0;
        end
        // Flags are sticky until a reset; a forced reset wins over a set in the same cycle.
        next_coc = charge_oc_flag || chg_expired;
        next_xot = ext_overtemp_flag || ext_overtemp_detect;
        next_iot = int_overtemp_flag || int_overtemp_detect;
        // Edge selected by the polarity bit; pin ignored when disabled.
        next_wake_event = !feature_cfg[`PPC_BIT_WAKE_DIS]
                          && (feature_cfg[`PPC_BIT_WAKE_POL] ? (wake_pin && !wake_prev)
                                                             : (!wake_pin && wake_prev));
        unique case (reg_addr)
            `PPC_ADDR_CHARGE: next_rdata = charge_cfg;
            `PPC_ADDR_FEATURE: next_rdata = feature_cfg;
            default: next_rdata = 8'h00;
        endcase
        if (!reg_rd) begin
            next_rdata = reg_rdata;
        end
        if (soft_por) begin
            next_charge_cfg = `PPC_RESET_VALUE;
            next_feature_cfg = `PPC_RESET_VALUE;
            next_charge_fet_on = 1'b0;
            next_coc = 1'b0;
            next_xot = 1'b0;
            next_iot = 1'b0;
            next_rdata = 8'h00;
            next_wake_event = 1'b0;
        end
    end

    // Outputs decoded from settings.
    always_comb begin
        charge_oc_threshold = charge_cfg[6:5];
        regulator_disable = feature_cfg[`PPC_BIT_REG_DIS];
        temp_sensor_supply_out = feature_cfg[`PPC_BIT_TEMP_FORCE] || charge_oc_flag || scan_on;
        power_fet_off_req = !charge_fet_on;
    end

    // State registers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            charge_cfg <= `PPC_RESET_VALUE;
            feature_cfg <= `PPC_RESET_VALUE;
            charge_fet_on <= 1'b0;
            charge_oc_flag <= 1'b0;
            ext_overtemp_flag <= 1'b0;
            int_overtemp_flag <= 1'b0;
            soft_por <= 1'b0;
            wake_prev <= 1'b0;
            wake_event <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            charge_cfg <= next_charge_cfg;
            feature_cfg <= next_feature_cfg;
            charge_fet_on <= next_charge_fet_on;
            charge_oc_flag <= next_coc;
            ext_overtemp_flag <= next_xot;
            int_overtemp_flag <= next_iot;
            soft_por <= next_soft_por;
            wake_prev <= wake_pin;
            wake_event <= next_wake_event;
            reg_rdata <= next_rdata;
        end
    end
endmodule : ppc_protect_regs

// ---- hdl/ppc_cfg.svh ----
// How it works
// - Auto-off disable bit zero lets charge FET drop
// - Charge overcurrent sets flag, powers sensor supply
// - Threshold field picks 0.10 to 0.16V
// - Short circuit delay 190us or 10ms
// - Charge divide bit shortens delay by 32
// - Discharge divide bit shortens delay by 64
// - Charge time-out 80 to 640ms codes
// - Temperature scan 5ms every 640ms
// - Regulator disable bit turns regulator off
// - Force bit keeps sensor supply on
// - External overtemp shutdown can be disabled
// - Internal overtemp shutdown can be disabled
// - Forced reset bit clears all registers
// - Wake pin disable ignores wake pin
// - Wake polarity picks rising or falling edge
// - Writes need their write-enable bit set
// - Auto shutoff clears the charge FET bit
// - Discharge time-outs 160 to 1280ms, divided
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
`define PPC_ADDR_DISCHARGE 8'h05
`define PPC_ADDR_CHARGE 8'h06
`define PPC_ADDR_FEATURE 8'h07
`define PPC_ADDR_WREN 8'h08
`define PPC_RESET_VALUE 8'h00
`define PPC_BIT_AUTOOFF_DIS 7
`define PPC_BIT_SC_LONG 4
`define PPC_BIT_CDIV 3
`define PPC_BIT_DDIV 2
`define PPC_BIT_SCAN_DIS 7
`define PPC_BIT_REG_DIS 6
`define PPC_BIT_TEMP_FORCE 5
`define PPC_BIT_XTSD_DIS 4
`define PPC_BIT_ITSD_DIS 3
`define PPC_BIT_FORCE_POR 2
`define PPC_BIT_WAKE_DIS 1
`define PPC_BIT_WAKE_POL 0
`define PPC_BIT_FEAT_WREN 7
`define PPC_BIT_CHG_WREN 6
`define PPC_BIT_DIS_WREN 5
`define PPC_CLK_MHZ 100
`define PPC_US_CYCLES(us) ((us) * `PPC_CLK_MHZ)
`define PPC_SC_SHORT_US 190
`define PPC_SC_LONG_US 10000
`define PPC_CHG_BASE_US 80000
`define PPC_DIS_BASE_US 160000
`define PPC_DIV_BASE_US 2500
`define PPC_SCAN_ON_US 5000
`define PPC_SCAN_PERIOD_US 640000
`endif

// ---- hdl/ppc_pkg.sv ----
package ppc_pkg;
    typedef logic [7:0] ppc_byte_type;
    typedef enum logic [1:0] {PPC_TH_010V, PPC_TH_012V, PPC_TH_014V, PPC_TH_016V} ppc_threshold_type;
    typedef enum {PPC_IDLE, PPC_TIMING, PPC_TRIPPED} ppc_timer_state_type;
endpackage : ppc_pkg

// ---- hdl/ppc_delay_timer.sv ----
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_delay_timer (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic soft_clear,
    // Condition and its required persistence in cycles.
    input wire logic cond,
    input wire logic [31:0] limit,
    // One-cycle pulse when the condition has persisted long enough.
    output logic expired
);
    ppc_pkg::ppc_timer_state_type state;
    ppc_pkg::ppc_timer_state_type next_state;
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_expired;

    // Counts while the condition holds and starts over as soon as it drops.
    always_comb begin
        next_state = state;
        next_count = count;
        next_expired = 1'b0;
        unique case (state)
            ppc_pkg::PPC_IDLE: begin
                next_count = 32'h00000001;
                if (cond) begin
                    next_state = ppc_pkg::PPC_TIMING;
                end
            end
            ppc_pkg::PPC_TIMING: begin
                if (!cond) begin
                    next_state = ppc_pkg::PPC_IDLE;
                end else if (count >= limit) begin
                    next_state = ppc_pkg::PPC_TRIPPED;
                    next_expired = 1'b1;
                end else begin
                    next_count = count + 32'h00000001;
                end
            end
            ppc_pkg::PPC_TRIPPED: begin
                if (!cond) begin
                    next_state = ppc_pkg::PPC_IDLE;
                end
            end
        endcase
        if (soft_clear) begin
            next_state = ppc_pkg::PPC_IDLE;
            next_expired = 1'b0;
        end
    end

    // State registers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ppc_pkg::PPC_IDLE;
            count <= 32'h00000001;
            expired <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            expired <= next_expired;
        end
    end
endmodule : ppc_delay_timer

// ---- hdl/ppc_temp_scan.sv ----
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_temp_scan (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic soft_clear,
    // Scan control.
    input wire logic scan_disable,
    // High during the on part of each scan period.
    output logic scan_on
);
    localparam logic [31:0] PERIOD = 32'(`PPC_US_CYCLES(`PPC_SCAN_PERIOD_US));
    localparam logic [31:0] ON_TIME = 32'(`PPC_US_CYCLES(`PPC_SCAN_ON_US));
    logic [31:0] phase;
    logic [31:0] next_phase;
    logic next_scan_on;

    // Free-running period counter; the supply is on for the first slice of each period.
    always_comb begin
        next_phase = (phase >= PERIOD - 32'h00000001) ? 32'h00000000 : phase + 32'h00000001;
        next_scan_on = !scan_disable && (next_phase < ON_TIME);
        if (soft_clear) begin
            next_phase = 32'h00000000;
            next_scan_on = 1'b0;
        end
    end

    // State registers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 32'h00000000;
            scan_on <= 1'b0;
        end else begin
            phase <= next_phase;
            scan_on <= next_scan_on;
        end
    end
endmodule : ppc_temp_scan

// ---- tb/ppc_protect_regs_asserts.sv ----
`timescale 1ns/1ps
module ppc_protect_regs_asserts (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic charge_cfg_write_enable,
    input wire logic feature_cfg_write_enable,
    // Levels and results.
    input wire logic short_circuit_detect,
    input wire logic ext_overtemp_detect,
    input wire logic [1:0] charge_oc_threshold,
    input wire logic charge_fet_on,
    input wire logic power_fet_off_req,
    input wire logic short_circuit_expired,
    input wire logic ext_overtemp_flag,
    input wire logic temp_sensor_supply_out,
    input wire logic regulator_disable,
    input wire logic soft_por
);
    logic [15:0] sc_run;
    logic [15:0] next_sc_run;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Counts unbroken cycles of short circuit; a drop starts it again.
    always_comb begin
        next_sc_run = 16'h0000;
        if (short_circuit_detect && !soft_por) begin
            next_sc_run = (sc_run == 16'hFFFF) ? sc_run : sc_run + 16'h0001;
        end
    end
    // Registers the run counter.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sc_run <= 16'h0000;
        end else begin
            sc_run <= next_sc_run;
        end
    end
    sequence chg_wr;
        reg_wr && reg_addr == 8'h06;
    endsequence
    sequence por_done;
        soft_por ##1 (regulator_disable == 1'b0 && charge_oc_threshold == 2'h0 && !ext_overtemp_flag);
    endsequence
    chk_fet_req_inverse: assert property (power_fet_off_req == !charge_fet_on) else $error("fet request mismatch");
    chk_thresh_write: assert property (chg_wr and charge_cfg_write_enable |=>
        charge_oc_threshold == $past(reg_wdata[6:5])) else $error("threshold not written");
    chk_write_refused: assert property (chg_wr and !charge_cfg_write_enable && !soft_por |=>
        $stable(charge_oc_threshold)) else $error("refused write took effect");
    chk_reg_disable: assert property (reg_wr && reg_addr == 8'h07 && feature_cfg_write_enable |=>
        regulator_disable == $past(reg_wdata[6])) else $error("regulator bit wrong");
    chk_supply_force: assert property (reg_wr && reg_addr == 8'h07 && feature_cfg_write_enable
        && reg_wdata[5] |=> temp_sensor_supply_out) else $error("sensor supply not forced");
    chk_por_clears: assert property (reg_wr && reg_addr == 8'h07 && feature_cfg_write_enable
        && reg_wdata[2] |-> ##[1:2] por_done) else $error("forced reset did not clear");
    chk_xot_sticky: assert property (ext_overtemp_flag && !soft_por |=> ext_overtemp_flag)
        else $error("overtemp flag lost");
    chk_xot_sets: assert property (ext_overtemp_detect && !soft_por |=> ext_overtemp_flag)
        else $error("overtemp flag not set");
    chk_sc_persist: assert property (short_circuit_expired |-> sc_run >= 16'h4A37)
        else $error("short circuit expired early");
    chk_rdata_thresh: assert property (reg_rd && reg_addr == 8'h06 |=>
        reg_rdata[6:5] == $past(charge_oc_threshold)) else $error("readback wrong");
endmodule : ppc_protect_regs_asserts
bind ppc_protect_regs ppc_protect_regs_asserts u_chk (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .charge_cfg_write_enable, .feature_cfg_write_enable, .short_circuit_detect, .ext_overtemp_detect,
    .charge_oc_threshold,
    .charge_fet_on, .power_fet_off_req, .short_circuit_expired, .ext_overtemp_flag, .temp_sensor_supply_out,
    .regulator_disable, .soft_por);

// ---- tb/ppc_host_model.sv ----
`timescale 1ns/1ps
module ppc_host_model (
    // Clock.
    input wire logic clk,
    // Register port toward the block.
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Write-enable bits of the enable register.
    output logic charge_cfg_write_enable,
    output logic feature_cfg_write_enable
);
    // Idle port and both enables clear, as at power-up.
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        charge_cfg_write_enable = 1'b0;
        feature_cfg_write_enable = 1'b0;
    end
    // Sets the write-enable bits.
    task automatic set_en(input logic c, input logic f);
        charge_cfg_write_enable <= c;
        feature_cfg_write_enable <= f;
        @(posedge clk);
    endtask : set_en
    // One write; address and data go to their inverse once released.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(posedge clk);
    endtask : wr
    // One read; data is taken a cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
endmodule : ppc_host_model

// ---- tb/pack_protection_config_regs_bench.sv ----
`timescale 1ns/1ps
module pack_protection_config_regs_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr, reg_rd, charge_cfg_write_enable, feature_cfg_write_enable;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [1:0] discharge_timeout_code = 2'h0;
    logic charge_oc_detect = 1'b0, discharge_oc_detect = 1'b0, short_circuit_detect = 1'b0;
    logic ext_overtemp_detect = 1'b0, int_overtemp_detect = 1'b0, wake_pin = 1'b0;
    logic charge_fet_set = 1'b0, charge_fet_clear = 1'b0, seen;
    logic [1:0] charge_oc_threshold;
    logic charge_fet_on, power_fet_off_req, discharge_oc_expired, short_circuit_expired, charge_oc_flag;
    logic ext_overtemp_flag, int_overtemp_flag, temp_sensor_supply_out, regulator_disable, wake_event, soft_por;
    int n_errors = 0, num_checks = 0, cyc = 0, i, j;
    ppc_protect_regs uut (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .charge_cfg_write_enable, .feature_cfg_write_enable, .discharge_timeout_code, .charge_oc_detect,
        .discharge_oc_detect, .short_circuit_detect, .ext_overtemp_detect, .int_overtemp_detect, .wake_pin,
        .charge_fet_set, .charge_fet_clear, .charge_oc_threshold, .charge_fet_on, .power_fet_off_req,
        .discharge_oc_expired, .short_circuit_expired, .charge_oc_flag, .ext_overtemp_flag, .int_overtemp_flag,
        .temp_sensor_supply_out, .regulator_disable, .wake_event, .soft_por);
    ppc_host_model h (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .charge_cfg_write_enable,
        .feature_cfg_write_enable);
    // Clock and hang guard.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            final_report();
        end
    end
    // Compares one value.
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Prints the verdict and stops.
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    // Reads a register and compares it.
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        h.rd(a, d);
        chk("rdata", e, d);
    endtask : rdc
    // Writes the feature register, makes one wake pin edge and looks for the event.
    task automatic wk_try(input logic [7:0] f, input logic from, input logic e);
        h.wr(8'h07, f);
        wake_pin <= from;
        repeat (3) @(posedge clk);
        wake_pin <= ~from;
        seen = 1'b0;
        repeat (4) begin
            @(posedge clk);
            if (wake_event === 1'b1) seen = 1'b1;
        end
        chk("wake", {7'h00, e}, {7'h00, seen});
    endtask : wk_try
    // Main sequence.
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rdc(8'h06, 8'h00);
        rdc(8'h07, 8'h00);
        rdc(8'h20, 8'h00);
        h.wr(8'h06, 8'h60);
        rdc(8'h06, 8'h00);
        h.set_en(1'b1, 1'b1);
        for (i = 0; i < 4; i++) begin
            h.wr(8'h06, {1'b0, i[1:0], 5'h00});
            chk("threshold", {6'h00, i[1:0]}, {6'h00, charge_oc_threshold});
            rdc(8'h06, {1'b0, i[1:0], 5'h00});
        end
        // The scan output follows its disable bit a cycle late, so wait until only the force bit holds the supply.
        h.wr(8'h07, 8'hE0);
        @(posedge clk);
        chk("regulator", 8'h01, {7'h00, regulator_disable});
        chk("supply forced", 8'h01, {7'h00, temp_sensor_supply_out});
        h.wr(8'h07, 8'h80);
        chk("supply off", 8'h00, {7'h00, temp_sensor_supply_out});
        short_circuit_detect <= 1'b1;
        repeat (10000) @(posedge clk);
        short_circuit_detect <= 1'b0;
        @(posedge clk);
        short_circuit_detect <= 1'b1;
        i = 0;
        while (short_circuit_expired !== 1'b1 && i < 20000) begin
            @(posedge clk);
            i++;
        end
        short_circuit_detect <= 1'b0;
        chk("sc delay", 8'h01, {7'h00, (i >= 18999 && i <= 19002)});
        for (j = 0; j < 2; j++) begin
            charge_fet_set <= 1'b1;
            @(posedge clk);
            charge_fet_set <= 1'b0;
            h.wr(8'h07, (j == 0) ? 8'h90 : 8'h88);
            if (j == 0) ext_overtemp_detect <= 1'b1;
            else int_overtemp_detect <= 1'b1;
            repeat (3) @(posedge clk);
            chk("overtemp flag", 8'h01, {7'h00, (j == 0) ? ext_overtemp_flag : int_overtemp_flag});
            chk("fet kept", 8'h01, {7'h00, charge_fet_on});
            h.wr(8'h07, 8'h80);
            repeat (3) @(posedge clk);
            chk("fet dropped", 8'h00, {7'h00, charge_fet_on});
            ext_overtemp_detect <= 1'b0;
            int_overtemp_detect <= 1'b0;
        end
        wk_try(8'h81, 1'b0, 1'b1);
        wk_try(8'h80, 1'b1, 1'b1);
        wk_try(8'h80, 1'b0, 1'b0);
        wk_try(8'h83, 1'b0, 1'b0);
        h.wr(8'h07, 8'h84);
        repeat (3) @(posedge clk);
        chk("flag cleared", 8'h00, {7'h00, ext_overtemp_flag});
        rdc(8'h07, 8'h00);
        final_report();
    end
endmodule : pack_protection_config_regs_bench
